// >>> sfpi_top.v
// serial flash pin interface control, device side, with apb view
// Behaviour
// - select falling starts an operation, select rising ends it.
// - deselected means standby, serial output floats.
// - serial input ignored while deselected or in reset.
// - timed program or erase keeps running after select rises.
// - command, address, write data sampled on rising serial clock.
// - read data changes on falling serial clock.
// - multi-lane reads drive io0 as data, two or four bits per fall.
// - serial output stays an output as data line one in multi-lane reads.
// - write-protect asserted refuses every status register write while quad enable is clear.
// - array protection from pin plus complement, granularity, top/bottom, block field.
// - quad enable turns write-protect pin into data line two.
// - data staged through a 256-byte buffer.
// - pause pin ignores clock and input, floats output; starts only selected, clock low, quad enable clear.
`timescale 1ns/10ps
`default_nettype none
`include "sfpi_consts.vh"
module sfpi_top #(
  parameter DUMMY_CLKS = `SFPI_DUMMY_CLKS,
  parameter BUF_AW     = 8
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        reset,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // flash pins
  input  wire        cs_n,
  input  wire        sck,
  input  wire        hold_n,
  input  wire [3:0]  io_i,
  output wire [3:0]  io_o,
  output wire [3:0]  io_oe,
  // array activity
  output wire        array_busy
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_CMD  = 7'h02;
  localparam [6:0] ST_ADDR = 7'h04;
  localparam [6:0] ST_DUMY = 7'h08;
  localparam [6:0] ST_DIN  = 7'h10;
  localparam [6:0] ST_DOUT = 7'h20;
  localparam [6:0] ST_DISC = 7'h40;

  // ----------------------------------------
  // pin synchronisation and edges
  // ----------------------------------------
  wire [6:0] pin_s;
  reg  [6:0] pin_p_q;

  sfpi_sync #(
    .W    (7),
    .INIT (`SFPI_PIN_RST)
  ) u_sync (
    .clk   (ref_clk),
    .reset (reset),
    .d     ({io_i, hold_n, sck, cs_n}),
    .q     (pin_s)
  );

  wire selected = ~pin_s[`SFPI_PIN_CS];
  wire cs_fall  = ~pin_s[`SFPI_PIN_CS] & pin_p_q[`SFPI_PIN_CS];
  wire cs_rise  = pin_s[`SFPI_PIN_CS] & ~pin_p_q[`SFPI_PIN_CS];
  wire sck_rise = pin_s[`SFPI_PIN_SCK] & ~pin_p_q[`SFPI_PIN_SCK];
  wire sck_fall = ~pin_s[`SFPI_PIN_SCK] & pin_p_q[`SFPI_PIN_SCK];
  wire si_bit   = pin_s[`SFPI_PIN_IO0];
  wire wp_n_s   = pin_s[`SFPI_PIN_IO2];

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  reg [6:0]  st_q;
  reg [7:0]  cmd_q;
  reg [6:0]  sh_q;
  reg [2:0]  bcnt_q;
  reg [1:0]  acnt_q;
  reg [23:0] addr_q;
  reg [3:0]  dcnt_q;
  reg [1:0]  nb_q;
  reg        frame_ok_q;
  reg [3:0]  mask_q;
  reg [7:0]  out_sh_q;
  reg [2:0]  out_left_q;
  reg        started_q;
  reg        pause_q;
  reg [7:0]  sr1_q;
  reg [7:0]  sr2_q;
  reg [7:0]  stg1_q;
  reg [7:0]  stg2_q;
  reg        wel_q;
  reg [15:0] busy_cnt_q;
  reg [15:0] ctrl_len_q;
  reg        refused_q;
  reg [3:0]  io_o_q;
  reg [3:0]  io_oe_q;
  reg [31:0] prdata_q;
  reg        pready_q;
  reg        pslverr_q;
  reg        busy_q;

  wire       busy    = |busy_cnt_q;
  wire       qe      = sr2_q[`SFPI_SR2_QE];
  // with quad enable the pin is data, so it no longer locks
  wire       hw_lock = ~wp_n_s & ~qe;
  wire [7:0] sr1_view = {sr1_q[7:2], wel_q, busy};

  // pause honoured only outside quad mode, where io3 is data
  wire pause_go = selected & ~qe & ~pin_s[`SFPI_PIN_HOLD] & ~pin_s[`SFPI_PIN_SCK];
  wire active   = selected & ~pause_q;
  wire rise_ok  = active & sck_rise;
  wire fall_ok  = active & sck_fall;

  wire [7:0] byte_v    = {sh_q, si_bit};
  wire       byte_done = rise_ok & (bcnt_q == 3'd7);

  // ----------------------------------------
  // array protection
  // ----------------------------------------
  function prot;
    input [23:0] a;
    input [2:0]  bp;
    input        tb;
    input        gran;
    input        cmp;
    reg   [3:0]  blk;
    reg   [3:0]  n;
    reg          hit;
    begin
      blk = gran ? a[15:12] : a[20:17];
      n   = 4'd1 << (bp - 3'd1);
      if (bp == 3'd0) begin
        hit = 1'b0;
      end else if (bp >= 3'd5) begin
        hit = 1'b1;
      end else if (tb) begin
        hit = (blk < n);
      end else begin
        hit = ({1'b0, blk} >= (5'd16 - {1'b0, n}));
      end
      prot = cmp ^ hit;
    end
  endfunction

  wire addr_prot = prot(addr_q, sr1_q[`SFPI_SR1_BP_HI:`SFPI_SR1_BP_LO], sr1_q[`SFPI_SR1_TB],
                        sr1_q[`SFPI_SR1_GRAN], sr2_q[`SFPI_SR2_CMP]);
  wire arr_lock  = addr_prot & ~wp_n_s & ~qe;

  // ----------------------------------------
  // staging buffer
  // ----------------------------------------
  wire       buf_wr = byte_done & st_q[4] & (cmd_q == `SFPI_CMD_PROG);
  wire [7:0] buf_rd;

  sfpi_buffer #(
    .AW (BUF_AW),
    .DW (8)
  ) u_buf (
    .clk     (ref_clk),
    .wr_en   (buf_wr),
    .wr_idx  (addr_q[BUF_AW-1:0]),
    .wr_data (byte_v),
    .rd_idx  (addr_q[BUF_AW-1:0]),
    .rd_data (buf_rd)
  );

  wire       from_buf = (cmd_q != `SFPI_CMD_RDSR1) && (cmd_q != `SFPI_CMD_RDSR2);
  wire [7:0] src_byte = (cmd_q == `SFPI_CMD_RDSR1) ? sr1_view :
                        (cmd_q == `SFPI_CMD_RDSR2) ? sr2_q : buf_rd;
  wire       first    = (out_left_q == 3'd0);
  wire [7:0] cur_byte = first ? src_byte : out_sh_q;

  // ----------------------------------------
  // serial engine
  // ----------------------------------------
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pin_p_q    <= `SFPI_PIN_RST;
      st_q       <= ST_IDLE;
      cmd_q      <= 8'h00;
      sh_q       <= 7'h00;
      bcnt_q     <= 3'h0;
      acnt_q     <= 2'h0;
      addr_q     <= 24'h000000;
      dcnt_q     <= 4'h0;
      nb_q       <= 2'h0;
      frame_ok_q <= 1'b0;
      mask_q     <= `SFPI_MASK_X1;
      out_sh_q   <= 8'h00;
      out_left_q <= 3'h0;
      started_q  <= 1'b0;
      pause_q    <= 1'b0;
      sr1_q      <= `SFPI_SR1_RST;
      sr2_q      <= `SFPI_SR2_RST;
      stg1_q     <= 8'h00;
      stg2_q     <= 8'h00;
      wel_q      <= 1'b0;
      busy_cnt_q <= 16'h0000;
      busy_q     <= 1'b0;
      refused_q  <= 1'b0;
      io_o_q     <= 4'h0;
      io_oe_q    <= 4'h0;
    end else begin
      pin_p_q <= pin_s;
      busy_q  <= busy;
      if (busy) begin
        busy_cnt_q <= busy_cnt_q - 16'h0001;
      end
      if (!selected) begin
        pause_q <= 1'b0;
      end else if (pause_q) begin
        pause_q <= ~pin_s[`SFPI_PIN_HOLD];
      end else if (pause_go) begin
        pause_q <= 1'b1;
      end
      // outputs float whenever not selected or paused
      io_oe_q <= (active & started_q & st_q[5]) ? mask_q : 4'h0;
      if (rise_ok) begin
        bcnt_q <= bcnt_q + 3'd1;
        sh_q   <= byte_v[6:0];
      end
      if (cs_fall) begin
        st_q       <= ST_CMD;
        bcnt_q     <= 3'h0;
        acnt_q     <= 2'h0;
        dcnt_q     <= 4'h0;
        nb_q       <= 2'h0;
        frame_ok_q <= 1'b0;
        out_left_q <= 3'h0;
        started_q  <= 1'b0;
        mask_q     <= `SFPI_MASK_X1;
      end else if (cs_rise) begin
        st_q      <= ST_IDLE;
        started_q <= 1'b0;
        // commit only on a byte boundary of a complete frame
        if (frame_ok_q && bcnt_q == 3'd0) begin
          case (cmd_q)
            `SFPI_CMD_WREN: begin
              wel_q <= 1'b1;
            end
            `SFPI_CMD_WRDI: begin
              wel_q <= 1'b0;
            end
            `SFPI_CMD_WRSR: begin
              if (wel_q && !hw_lock) begin
                sr1_q <= {stg1_q[7:2], 2'b00};
                if (nb_q == 2'd2) begin
                  sr2_q <= stg2_q;
                end
              end else begin
                refused_q <= 1'b1;
              end
              wel_q <= 1'b0;
            end
            `SFPI_CMD_PROG, `SFPI_CMD_ERASE: begin
              if (wel_q && !arr_lock && !busy) begin
                busy_cnt_q <= ctrl_len_q;
              end else begin
                refused_q <= 1'b1;
              end
              wel_q <= 1'b0;
            end
            default: begin
            end
          endcase
        end
      end else begin
        case (st_q)
          ST_CMD: begin
            if (byte_done) begin
              cmd_q <= byte_v;
              if (busy && byte_v != `SFPI_CMD_RDSR1) begin
                st_q <= ST_DISC;
              end else begin
                case (byte_v)
                  `SFPI_CMD_WREN, `SFPI_CMD_WRDI: begin
                    st_q       <= ST_DISC;
                    frame_ok_q <= 1'b1;
                  end
                  `SFPI_CMD_RDSR1, `SFPI_CMD_RDSR2: begin
                    st_q <= ST_DOUT;
                  end
                  `SFPI_CMD_WRSR: begin
                    st_q <= ST_DIN;
                  end
                  `SFPI_CMD_READ, `SFPI_CMD_PROG, `SFPI_CMD_ERASE: begin
                    st_q <= ST_ADDR;
                  end
                  `SFPI_CMD_DREAD: begin
                    st_q   <= ST_ADDR;
                    mask_q <= `SFPI_MASK_X2;
                  end
                  `SFPI_CMD_QREAD: begin
                    st_q   <= qe ? ST_ADDR : ST_DISC;
                    mask_q <= `SFPI_MASK_X4;
                  end
                  default: begin
                    st_q <= ST_DISC;
                  end
                endcase
              end
            end
          end
          ST_ADDR: begin
            if (byte_done) begin
              addr_q <= {addr_q[15:0], byte_v};
              acnt_q <= acnt_q + 2'd1;
              if (acnt_q == 2'd2) begin
                case (cmd_q)
                  `SFPI_CMD_READ: begin
                    st_q <= ST_DOUT;
                  end
                  `SFPI_CMD_PROG: begin
                    st_q <= ST_DIN;
                  end
                  `SFPI_CMD_ERASE: begin
                    st_q       <= ST_DISC;
                    frame_ok_q <= 1'b1;
                  end
                  default: begin
                    st_q <= ST_DUMY;
                  end
                endcase
              end
            end
          end
          ST_DUMY: begin
            if (rise_ok) begin
              dcnt_q <= dcnt_q + 4'd1;
              if (dcnt_q == DUMMY_CLKS - 1) begin
                st_q <= ST_DOUT;
              end
            end
          end
          ST_DIN: begin
            if (byte_done) begin
              frame_ok_q <= 1'b1;
              if (nb_q != 2'd2) begin
                nb_q <= nb_q + 2'd1;
              end
              if (cmd_q == `SFPI_CMD_WRSR) begin
                if (nb_q == 2'd0) begin
                  stg1_q <= byte_v;
                end else if (nb_q == 2'd1) begin
                  stg2_q <= byte_v;
                end
              end else begin
                addr_q[7:0] <= addr_q[7:0] + 8'd1;
              end
            end
          end
          ST_DOUT: begin
            if (fall_ok) begin
              started_q <= 1'b1;
              case (mask_q)
                `SFPI_MASK_X4: begin
                  io_o_q     <= cur_byte[7:4];
                  out_sh_q   <= {cur_byte[3:0], 4'h0};
                  out_left_q <= first ? 3'd1 : out_left_q - 3'd1;
                end
                `SFPI_MASK_X2: begin
                  io_o_q     <= {2'b00, cur_byte[7:6]};
                  out_sh_q   <= {cur_byte[5:0], 2'b00};
                  out_left_q <= first ? 3'd3 : out_left_q - 3'd1;
                end
                default: begin
                  io_o_q     <= {2'b00, cur_byte[7], 1'b0};
                  out_sh_q   <= {cur_byte[6:0], 1'b0};
                  out_left_q <= first ? 3'd7 : out_left_q - 3'd1;
                end
              endcase
              if (first && from_buf) begin
                addr_q[7:0] <= addr_q[7:0] + 8'd1;
              end
            end
          end
          default: begin
          end
        endcase
      end
      if (psel && penable && pready_q && pwrite && paddr == `SFPI_OFS_STATUS
          && pwdata[`SFPI_ST_REFUSE] && !(cs_rise && frame_ok_q)) begin
        refused_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  wire [31:0] status_w = {12'h000, refused_q, hw_lock, pause_q, selected, sr2_q, sr1_view};
  wire        hit_any  = (paddr == `SFPI_OFS_CTRL) || (paddr == `SFPI_OFS_STATUS) ||
                         (paddr == `SFPI_OFS_ADDR);

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_len_q <= `SFPI_CTRL_RST;
      prdata_q   <= 32'h00000000;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~hit_any;
      if (psel && !penable) begin
        case (paddr)
          `SFPI_OFS_CTRL: begin
            prdata_q <= {16'h0000, ctrl_len_q};
          end
          `SFPI_OFS_STATUS: begin
            prdata_q <= status_w;
          end
          `SFPI_OFS_ADDR: begin
            prdata_q <= {8'h00, addr_q};
          end
          default: begin
            prdata_q <= 32'h00000000;
          end
        endcase
      end
      if (psel && penable && pready_q && pwrite && paddr == `SFPI_OFS_CTRL) begin
        ctrl_len_q <= pwdata[15:0];
      end
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign io_o       = io_o_q;
  assign io_oe      = io_oe_q;
  assign array_busy = busy_q;

endmodule
`default_nettype wire

// >>> sfpi_consts.vh
// shared constants of the serial flash pin interface
`ifndef SFPI_CONSTS_VH
`define SFPI_CONSTS_VH

// ----------------------------------------
// apb register offsets
// ----------------------------------------
`define SFPI_OFS_CTRL       12'h000
`define SFPI_OFS_STATUS     12'h004
`define SFPI_OFS_ADDR       12'h008

// ----------------------------------------
// reset values
// ----------------------------------------
`define SFPI_CTRL_RST       16'h0100
`define SFPI_SR1_RST        8'h00
`define SFPI_SR2_RST        8'h00
`define SFPI_PIN_RST        7'h7d

// ----------------------------------------
// apb status word fields
// ----------------------------------------
`define SFPI_ST_SR1_LO      0
`define SFPI_ST_SR2_LO      8
`define SFPI_ST_SEL         16
`define SFPI_ST_PAUSE       17
`define SFPI_ST_LOCK        18
`define SFPI_ST_REFUSE      19

// ----------------------------------------
// flash status register fields
// ----------------------------------------
`define SFPI_SR1_BUSY       0
`define SFPI_SR1_WEL        1
`define SFPI_SR1_BP_LO      2
`define SFPI_SR1_BP_HI      4
`define SFPI_SR1_TB         5
`define SFPI_SR1_GRAN       6
`define SFPI_SR2_QE         1
`define SFPI_SR2_CMP        6

// ----------------------------------------
// synchronised pin vector positions
// ----------------------------------------
`define SFPI_PIN_CS         0
`define SFPI_PIN_SCK        1
`define SFPI_PIN_HOLD       2
`define SFPI_PIN_IO0        3
`define SFPI_PIN_IO2        5

// ----------------------------------------
// serial commands
// ----------------------------------------
`define SFPI_CMD_WREN       8'h06
`define SFPI_CMD_WRDI       8'h04
`define SFPI_CMD_RDSR1      8'h05
`define SFPI_CMD_RDSR2      8'h35
`define SFPI_CMD_WRSR       8'h01
`define SFPI_CMD_READ       8'h03
`define SFPI_CMD_DREAD      8'h3b
`define SFPI_CMD_QREAD      8'h6b
`define SFPI_CMD_PROG       8'h02
`define SFPI_CMD_ERASE      8'h20

// ----------------------------------------
// lane masks and timing counts
// ----------------------------------------
`define SFPI_MASK_X1        4'h2
`define SFPI_MASK_X2        4'h3
`define SFPI_MASK_X4        4'hf
`define SFPI_DUMMY_CLKS     8

`endif

// >>> sfpi_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module sfpi_sync #(
  parameter       W    = 7,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // clock and reset
  input  wire         clk,
  input  wire         reset,
  // pins in, filtered levels out
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg lvl_q;
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          s1_q  <= INIT[i];
          s2_q  <= INIT[i];
          s3_q  <= INIT[i];
          lvl_q <= INIT[i];
        end else begin
          s1_q <= d[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // s1 feeds only s2; the filter looks at later stages
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
        end
      end
      assign q[i] = lvl_q;
    end
  endgenerate

endmodule
`default_nettype wire

// >>> sfpi_buffer.v
// byte staging buffer between serial side and array
`timescale 1ns/10ps
`default_nettype none
module sfpi_buffer #(
  parameter AW = 8,
  parameter DW = 8
) (
  // clock
  input  wire          clk,
  // write port
  input  wire          wr_en,
  input  wire [AW-1:0] wr_idx,
  input  wire [DW-1:0] wr_data,
  // read port
  input  wire [AW-1:0] rd_idx,
  output wire [DW-1:0] rd_data
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // contents are data, not control, so no reset
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  assign rd_data = mem[rd_idx];

endmodule
`default_nettype wire

// >>> sfpi_chk.sv
// assertion checker for the serial flash pin interface
`timescale 1ns/10ps
`default_nettype none
`include "sfpi_consts.vh"
module sfpi_chk #(
  parameter int DUMMY_CLKS = 8,
  parameter int BUF_AW     = 8
) (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // flash pins
  input wire logic        cs_n,
  input wire logic        sck,
  input wire logic        hold_n,
  input wire logic [3:0]  io_o,
  input wire logic [3:0]  io_oe,
  input wire logic        array_busy
);
  logic       sck_q;
  logic [3:0] fall_age_q;
  // --------------------------------
  // cycles since raw sck last fell
  // --------------------------------
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sck_q      <= 1'b0;
      fall_age_q <= 4'hf;
    end else begin
      sck_q <= sck;
      if (sck_q && !sck) begin
        fall_age_q <= 4'h0;
      end else if (fall_age_q != 4'hf) begin
        fall_age_q <= fall_age_q + 4'h1;
      end
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  chk_apb_answer: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_decode: assert property (pready |-> pslverr == !(paddr == `SFPI_OFS_CTRL ||
    paddr == `SFPI_OFS_STATUS || paddr == `SFPI_OFS_ADDR))
    else $error("pslverr wrong for address");
  chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("pslverr without zero data");
  chk_float_idle: assert property (cs_n [*8] |-> io_oe == 4'h0)
    else $error("pins driven while deselected");
  chk_idle_still: assert property (cs_n [*8] |=> $stable(io_o))
    else $error("output moved while deselected");
  chk_lane_mask: assert property (io_oe == 4'h0 || io_oe == `SFPI_MASK_X1 ||
    io_oe == `SFPI_MASK_X2 || io_oe == `SFPI_MASK_X4)
    else $error("illegal lane enable");
  chk_hold_float: assert property (!hold_n [*8] |-> io_oe == 4'h0)
    else $error("pins driven while paused");
  chk_out_on_fall: assert property ($changed(io_o) && io_oe != 4'h0 && !cs_n |-> fall_age_q <= 4'h8)
    else $error("output changed away from sck fall");
  chk_busy_commit: assert property ($rose(array_busy) |-> cs_n)
    else $error("timed cycle started inside a frame");
endmodule
bind sfpi_top sfpi_chk #(.DUMMY_CLKS(DUMMY_CLKS), .BUF_AW(BUF_AW)) u_chk (
  .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .cs_n(cs_n), .sck(sck),
  .hold_n(hold_n), .io_o(io_o), .io_oe(io_oe), .array_busy(array_busy)
);
`default_nettype wire

// >>> sfpi_host.sv
// spi host model driving the flash pins, mode 0, 400 ns sck
`timescale 1ns/10ps
`default_nettype none
module sfpi_host (
  // flash pins
  output var logic       cs_n,
  output var logic       sck,
  output var logic       hold_n,
  output var logic [3:0] h_o,
  output var logic [3:0] h_oe,
  // resolved pin levels
  input wire logic [3:0] io_w
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    hold_n = 1'b1;
    h_o = 4'h0;
    h_oe = 4'h0;
  end
  // odd offset keeps pin edges off the ref_clk sampling edge
  task automatic start;
    #13 cs_n = 1'b0;
    h_oe[0] = 1'b1;
    #200;
  endtask
  task automatic stop;
    #100 cs_n = 1'b1;
    h_oe[0] = 1'b0;
    #400;
  endtask
  // sampled late: device output lags the pin fall by the filter
  task automatic bit_clk(input logic d, output logic [3:0] s);
    h_o[0] = d;
    #200 sck = 1'b1;
    #100 s = io_w;
    #100 sck = 1'b0;
  endtask
  task automatic send(input logic [7:0] b, input int n = 8);
    logic [3:0] s;
    for (int i = 7; i > 7 - n; i--) bit_clk(b[i], s);
  endtask
  task automatic dummy(input int n);
    logic [3:0] s;
    h_oe[0] = 1'b0;
    repeat (n) bit_clk(1'b0, s);
  endtask
  task automatic recv(input int lanes, output logic [7:0] b);
    logic [3:0] s;
    h_oe[0] = (lanes == 1);
    for (int i = 0; i < 8 / lanes; i++) begin
      bit_clk(1'b0, s);
      b = (lanes == 1) ? {b[6:0], s[1]} : (lanes == 2) ? {b[5:0], s[1:0]} : {b[3:0], s};
    end
  endtask
  task automatic set_wp(input logic on);
    h_oe[2] = on;
    #300;
  endtask
  // pause only while selected and sck low
  task automatic pause(input logic on);
    #100 hold_n = !on;
    #700;
  endtask
endmodule
`default_nettype wire

// >>> tb_serial_flash_pin_interface.sv
// self-checking bench for the serial flash pin interface
`timescale 1ns/10ps
`default_nettype none
`include "sfpi_consts.vh"
module tb_serial_flash_pin_interface;
  localparam int DUMMY = 8;
  logic        ref_clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        flip_q;
  wire  [31:0] prdata;
  wire         pready, pslverr, array_busy, cs_n, sck, hold_n;
  wire  [3:0]  io_o, io_oe, h_o, h_oe, io_w;
  int          err_count;
  int          n_compared;
  logic [31:0] rd;
  logic [7:0]  b;
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // undriven data lines never look steady; io2 and io3 pulled up
  always @(posedge ref_clk) flip_q <= (flip_q !== 1'b1);
  assign io_w = (io_oe & io_o) | (~io_oe & h_oe & h_o) | (~io_oe & ~h_oe & {2'b11, flip_q, ~flip_q});
  sfpi_top #(.DUMMY_CLKS(DUMMY)) uut (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cs_n(cs_n), .sck(sck), .hold_n(hold_n), .io_i(io_w), .io_o(io_o), .io_oe(io_oe),
    .array_busy(array_busy)
  );
  sfpi_host host (.cs_n(cs_n), .sck(sck), .hold_n(hold_n), .h_o(h_o), .h_oe(h_oe), .io_w(io_w));
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = pslverr ? {1'b1, prdata[30:0]} : prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      check("pready", {31'h0, pready}, 32'h1);
      end_sim();
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic [31:0] a, input int na);
    host.start();
    host.send(c);
    for (int i = na - 1; i >= 0; i--) host.send(a[8*i +: 8]);
  endtask
  task automatic wren;
    cmd(`SFPI_CMD_WREN, 32'h0, 0);
    host.stop();
  endtask
  task automatic wrsr(input logic [15:0] v);
    wren();
    cmd(`SFPI_CMD_WRSR, {16'h0, v}, 2);
    host.stop();
  endtask
  task automatic rd_sr(input string nm);
    cmd(`SFPI_CMD_RDSR1, 32'h0, 0);
    host.recv(1, b);
    check(nm, {24'h0, b}, 32'h0c);
    check("oe_x1", {28'h0, io_oe}, `SFPI_MASK_X1);
    host.stop();
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_regs;
    apb(1'b0, `SFPI_OFS_CTRL, 32'h0);
    check("ctrl", rd, {16'h0, `SFPI_CTRL_RST});
    apb(1'b1, `SFPI_OFS_STATUS, 32'hff);
    apb(1'b0, `SFPI_OFS_STATUS, 32'h0);
    check("status", rd, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    check("unmapped", rd, 32'h8000_0000);
    apb(1'b1, `SFPI_OFS_CTRL, 32'h10);
    $display("t_regs done");
  endtask
  task automatic t_status;
    wrsr(16'h0f00);
    apb(1'b0, `SFPI_OFS_STATUS, 32'h0);
    check("sr1", rd, 32'h0c);
    rd_sr("rdsr1");
    check("oe_off", {28'h0, io_oe}, 32'h0);
    host.set_wp(1'b1);
    wrsr(16'h1c00);
    apb(1'b0, `SFPI_OFS_STATUS, 32'h0);
    check("locked", rd, 32'h000c_000c);
    host.set_wp(1'b0);
    apb(1'b1, `SFPI_OFS_STATUS, 32'h0008_0000);
    // partial frame, then clocks while deselected
    host.start();
    host.send(8'h06);
    host.send(8'h06, 4);
    host.stop();
    host.send(8'h06);
    apb(1'b0, `SFPI_OFS_STATUS, 32'h0);
    check("wel", rd, 32'h0c);
    rd_sr("resync");
    cmd(`SFPI_CMD_RDSR1, 32'h0, 0);
    host.pause(1'b1);
    check("oe_hold", {28'h0, io_oe}, 32'h0);
    host.send(8'hff);
    host.pause(1'b0);
    host.recv(1, b);
    check("after_hold", {24'h0, b}, 32'h0c);
    host.stop();
    $display("t_status done");
  endtask
  task automatic t_prog;
    wren();
    cmd(`SFPI_CMD_PROG, 32'h10, 3);
    host.send(8'ha5);
    host.send(8'h3c);
    host.stop();
    check("busy", {31'h0, array_busy}, 32'h1);
    for (int n = 0; n < 100 && array_busy !== 1'b0; n++) @(posedge ref_clk);
    check("idle", {31'h0, array_busy}, 32'h0);
    host.set_wp(1'b1);
    wren();
    cmd(`SFPI_CMD_ERASE, 32'h1e_0000, 3);
    host.stop();
    check("prot", {31'h0, array_busy}, 32'h0);
    host.set_wp(1'b0);
    apb(1'b0, `SFPI_OFS_STATUS, 32'h0);
    check("refused", rd, 32'h0008_000c);
    cmd(`SFPI_CMD_READ, 32'h10, 3);
    host.recv(1, b);
    check("buf0", {24'h0, b}, 32'ha5);
    host.recv(1, b);
    check("buf1", {24'h0, b}, 32'h3c);
    host.stop();
    $display("t_prog done");
  endtask
  task automatic t_multi;
    cmd(`SFPI_CMD_DREAD, 32'h10, 3);
    host.dummy(DUMMY);
    host.recv(2, b);
    check("x2", {24'h0, b}, 32'ha5);
    check("oe_x2", {28'h0, io_oe}, `SFPI_MASK_X2);
    host.stop();
    wrsr(16'h0c02);
    cmd(`SFPI_CMD_RDSR2, 32'h0, 0);
    host.recv(1, b);
    check("sr2", {24'h0, b}, 32'h02);
    host.stop();
    cmd(`SFPI_CMD_QREAD, 32'h10, 3);
    host.dummy(DUMMY);
    host.recv(4, b);
    check("x4a", {24'h0, b}, 32'ha5);
    host.recv(4, b);
    check("x4b", {24'h0, b}, 32'h3c);
    check("oe_x4", {28'h0, io_oe}, `SFPI_MASK_X4);
    host.stop();
    $display("t_multi done");
  endtask
  initial begin
    reset <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h0;
    pwdata <= 32'h0;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_regs();
    t_status();
    t_prog();
    t_multi();
    end_sim();
  end
endmodule
`default_nettype wire
